// [cfg_regs_defs.vh]
// command codes, field positions and reset values for the initialization register bank
// assumes a byte-wide command/data port driven by the external controller
//
// Functional notes
// - usb bus reset disables every endpoint
// - fifo allocation only after all sixteen endpoints configured in order
// - allocation starts when the endpoint 15 configuration write completes
// - size or enable change invalidates all endpoint fifo contents
// - codes 0x20-0x2F write, 0x30-0x3F read endpoint configuration, one byte
// - bit 7 enables the endpoint buffer with memory allocated
// - bit 6 direction: 0 out, 1 in; also dma direction
// - bit 5 selects double buffering
// - bit 4 selects isochronous, else bulk or interrupt
// - bits 3..0 hold the buffer size code
// - bus reset sets working address to 0x00 and enables the device
// - bus reset leaves the software-visible address register unchanged
// - new address takes effect only when the status packet is acknowledged
// - 0xB6 writes, 0xB7 reads address register; bit 7 enable, 6..0 address
// - 0xB8 writes, 0xB9 reads mode register; upper byte ignored in 16-bit mode
// - debug bit 2 makes every error and nak raise an interrupt
// - mode bits: 7 dma width, 5 suspend, 3 int enable, 2 debug, 0 attach
// - dma width bit one selects 16-bit dma bus, zero 8-bit
// - suspend entered on a one-then-zero write sequence of bit 5
`ifndef CFG_REGS_DEFS_VH
`define CFG_REGS_DEFS_VH
`define EP_WR_BASE 8'h20
`define EP_RD_BASE 8'h30
`define EP_CODE_HI_MASK 8'hF0
`define EP_LAST 4'hF
`define ADDR_WR 8'hB6
`define ADDR_RD 8'hB7
`define MODE_WR 8'hB8
`define MODE_RD 8'hB9
`define BYTE_ZERO 8'h00
`define EPC_EN 7
`define EPC_DIR 6
`define EPC_DBL 5
`define EPC_ISO 4
`define EPC_SZ_HI 3
`define EPC_ALLOC_MASK 8'h8F
`define ADR_EN 7
`define MODE_DMA_WIDTH_SELECT 7
`define MODE_SUSP 5
`define MODE_INTEN 3
`define MODE_DBG 2
`define MODE_ATTACH 0
`define MODE_KEEP_MASK 8'h8F
`endif

// [cfg_regs.v]
// initialization register bank: endpoint configuration, device address, mode
// assumes cmd_valid/cmd_code/wr_data are synchronous to mclk, one byte per access
`include "cfg_regs_defs.vh"

module cfg_regs #(
    parameter num_ep = 16
) (
    input wire mclk,
    input wire nrst,
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire [7:0] wr_data,
    input wire usb_bus_reset,
    input wire status_ack,
    input wire [3:0] cfg_sel,
    output reg [7:0] rd_data,
    output reg rd_valid,
    output reg [7:0] sel_config,
    output reg [num_ep-1:0] ep_enabled,
    output reg alloc_start,
    output reg fifo_invalidate,
    output reg [6:0] active_address,
    output reg device_enable,
    output reg dma_width_select,
    output reg interrupt_output_enable,
    output reg debug_all_events,
    output reg soft_bus_attach,
    output reg suspend_req
);

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire ep_wr = cmd_valid && ((cmd_code & `EP_CODE_HI_MASK) == `EP_WR_BASE);
    wire ep_rd = cmd_valid && ((cmd_code & `EP_CODE_HI_MASK) == `EP_RD_BASE);
    wire [3:0] ep_idx = cmd_code[3:0];
    wire adr_wr = cmd_valid && (cmd_code == `ADDR_WR);
    wire adr_rd = cmd_valid && (cmd_code == `ADDR_RD);
    wire mode_wr = cmd_valid && (cmd_code == `MODE_WR);
    wire mode_rd = cmd_valid && (cmd_code == `MODE_RD);

    // ------------------------------------------------------------
    // endpoint configuration array
    // ------------------------------------------------------------
    reg [7:0] ep_cfg_q [0:num_ep-1];
    reg [3:0] seq_next_q;
    reg seq_done_q;
    reg [7:0] mode_q;
    reg [7:0] addr_q;
    reg pending_q;
    reg [6:0] pend_addr_q;

    genvar g;
    generate
        for (g = 0; g < num_ep; g = g + 1) begin : g_ep
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    ep_cfg_q[g] <= `BYTE_ZERO;
                end else if (usb_bus_reset) begin
                    ep_cfg_q[g] <= ep_cfg_q[g] & ~(8'h01 << `EPC_EN);
                end else if (ep_wr && ep_idx == g) begin
                    ep_cfg_q[g] <= wr_data;
                end
            end
        end
    endgenerate

    // any enable or size change of an already-allocated bank loses all data
    wire [7:0] old_cfg = ep_cfg_q[ep_idx];
    // writes taken during a bus reset are dropped, so they must not move the tracker either
    wire ep_wr_live = ep_wr && !usb_bus_reset;
    wire alloc_change = ep_wr_live && (((old_cfg ^ wr_data) & `EPC_ALLOC_MASK) != `BYTE_ZERO);

    // ------------------------------------------------------------
    // allocation sequence tracking
    // ------------------------------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            seq_next_q <= 4'h0;
            seq_done_q <= 1'b0;
            alloc_start <= 1'b0;
            fifo_invalidate <= 1'b0;
        end else begin
            alloc_start <= 1'b0;
            fifo_invalidate <= usb_bus_reset || (alloc_change && seq_done_q);
            if (ep_wr_live) begin
                // out-of-order write restarts the sequence; endpoint 0 out starts it afresh
                if (ep_idx == seq_next_q) begin
                    if (ep_idx == `EP_LAST) begin
                        seq_next_q <= 4'h0;
                        seq_done_q <= 1'b1;
                        alloc_start <= 1'b1;
                    end else begin
                        seq_next_q <= ep_idx + 4'h1;
                    end
                end else if (ep_idx == 4'h0) begin
                    seq_next_q <= 4'h1;
                end else begin
                    seq_next_q <= 4'h0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // address register and deferred activation
    // ------------------------------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= `BYTE_ZERO;
            pending_q <= 1'b0;
            pend_addr_q <= 7'h00;
            active_address <= 7'h00;
            device_enable <= 1'b0;
        end else if (usb_bus_reset) begin
            // addr_q deliberately kept
            active_address <= 7'h00;
            device_enable <= 1'b1;
            pending_q <= 1'b0;
        end else begin
            if (adr_wr) begin
                addr_q <= wr_data;
                device_enable <= wr_data[`ADR_EN];
                pending_q <= 1'b1;
                pend_addr_q <= wr_data[6:0];
            end else if (pending_q && status_ack) begin
                active_address <= pend_addr_q;
                pending_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // mode register and suspend detection
    // ------------------------------------------------------------
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= `BYTE_ZERO;
            suspend_req <= 1'b0;
        end else begin
            suspend_req <= 1'b0;
            if (usb_bus_reset) begin
                mode_q <= mode_q & `MODE_KEEP_MASK;
            end else if (mode_wr) begin
                mode_q <= wr_data;
                suspend_req <= mode_q[`MODE_SUSP] && !wr_data[`MODE_SUSP];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs and read-back
    // ------------------------------------------------------------
    integer i;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= `BYTE_ZERO;
            rd_valid <= 1'b0;
            sel_config <= `BYTE_ZERO;
            ep_enabled <= {num_ep{1'b0}};
            dma_width_select <= 1'b0;
            interrupt_output_enable <= 1'b0;
            debug_all_events <= 1'b0;
            soft_bus_attach <= 1'b0;
        end else begin
            rd_valid <= ep_rd || adr_rd || mode_rd;
            if (ep_rd) begin
                rd_data <= ep_cfg_q[ep_idx];
            end else if (adr_rd) begin
                rd_data <= addr_q;
            end else if (mode_rd) begin
                rd_data <= mode_q;
            end
            sel_config <= ep_cfg_q[cfg_sel];
            for (i = 0; i < num_ep; i = i + 1) begin
                ep_enabled[i] <= ep_cfg_q[i][`EPC_EN] && seq_done_q;
            end
            dma_width_select <= mode_q[`MODE_DMA_WIDTH_SELECT];
            interrupt_output_enable <= mode_q[`MODE_INTEN];
            debug_all_events <= mode_q[`MODE_DBG];
            soft_bus_attach <= mode_q[`MODE_ATTACH];
        end
    end

endmodule // cfg_regs

// [cfg_regs_chk.sv]
// port checks for the configuration register bank
// assumes a bind onto cfg_regs, one clock domain
`include "cfg_regs_defs.vh"
module cfg_regs_chk #(parameter num_ep = 16) (
    input wire mclk, input wire nrst, input wire cmd_valid, input wire [7:0] cmd_code,
    input wire [7:0] wr_data, input wire usb_bus_reset, input wire status_ack, input wire rd_valid,
    input wire [num_ep-1:0] ep_enabled, input wire alloc_start, input wire fifo_invalidate,
    input wire [6:0] active_address, input wire device_enable, input wire dma_width_select,
    input wire interrupt_output_enable, input wire debug_all_events, input wire soft_bus_attach,
    input wire suspend_req
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire rd_cmd = cmd_valid && (cmd_code[7:4] == 4'h3 || cmd_code == `ADDR_RD || cmd_code == `MODE_RD);
    wire mw = cmd_valid && cmd_code == `MODE_WR && !usb_bus_reset;
    sequence s_arm; mw && wr_data[`MODE_SUSP]; endsequence
    sequence s_drop; mw && !wr_data[`MODE_SUSP]; endsequence
    a_read_answer: assert property (rd_cmd |=> rd_valid) else $error("read unanswered");
    a_read_quiet: assert property (!rd_cmd |=> !rd_valid) else $error("stray read answer");
    a_alloc_cause: assert property (alloc_start |-> $past(cmd_valid && cmd_code == 8'h2F)) else $error("stray alloc");
    // enables are derived from the stored bits, hence two cycles
    a_reset_disable: assert property (usb_bus_reset |-> ##2 ep_enabled == '0) else $error("ep enabled");
    a_reset_addr: assert property (usb_bus_reset |=> active_address == 7'h00 && device_enable)
        else $error("bus reset address");
    a_reset_inval: assert property (usb_bus_reset |=> fifo_invalidate) else $error("no invalidate");
    a_addr_defer: assert property ($changed(active_address) |-> $past(status_ack) || $past(usb_bus_reset))
        else $error("early address");
    a_mode_apply: assert property (mw |-> ##2 {dma_width_select, interrupt_output_enable, debug_all_events,
        soft_bus_attach} == $past({wr_data[7], wr_data[3:2], wr_data[0]}, 2)) else $error("mode bits");
    a_suspend_seq: assert property (s_arm ##1 !cmd_valid ##1 s_drop |=> suspend_req) else $error("no suspend");
endmodule // cfg_regs_chk

// [fw_port_model.sv]
// controller model: one byte access per call, then a free cycle
// assumes reads are answered on the cycle after the taking edge
module fw_port_model (
    input wire mclk,
    input wire [7:0] rd_data,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {cmd_valid, cmd_code, wr_data} = 17'h0;
    task automatic access(input logic [7:0] c, input logic [7:0] d, output logic [7:0] q);
        @(negedge mclk);
        {cmd_valid, cmd_code, wr_data} = {1'b1, c, d};
        @(negedge mclk);
        // idle lines flip so a stale byte never passes for a live one
        {cmd_valid, cmd_code, wr_data} = {1'b0, ~c, ~d};
        q = rd_data;
    endtask
endmodule // fw_port_model

// [usb_device_init_config_regs_tb_top.sv]
// self-checking bench for the configuration register bank
// assumes cfg_regs, fw_port_model and cfg_regs_chk are compiled first
`include "cfg_regs_defs.vh"
module usb_device_init_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ctl_default = 8'h80; // plain control endpoint default
    logic mclk, nrst, usb_bus_reset, status_ack;
    logic [3:0] cfg_sel;
    logic [7:0] q, m, ep_val [16];
    wire cmd_valid, rd_valid, alloc_start, fifo_invalidate, device_enable, suspend_req;
    wire dma_width_select, interrupt_output_enable, debug_all_events, soft_bus_attach;
    wire [7:0] cmd_code, wr_data, rd_data, sel_config;
    wire [15:0] ep_enabled;
    wire [6:0] active_address;
    integer seed = 59060, num_errors = 0, compares = 0, n_alloc = 0, n_inval = 0, n_susp = 0;
    cfg_regs #(.num_ep(16)) i_cfg_regs (.*);
    fw_port_model i_fw_port_model (.*);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        n_alloc += (alloc_start === 1'b1);
        n_inval += (fifo_invalidate === 1'b1);
        n_susp += (suspend_req === 1'b1);
    end
    function automatic logic [15:0] en_map();
        for (int i = 0; i < 16; i++) en_map[i] = ep_val[i][`EPC_EN];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
        i_fw_port_model.access(c, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic give_verdict();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
    initial begin
        {nrst, usb_bus_reset, status_ack, cfg_sel} = 7'h0;
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        for (int i = 0; i < 16; i++) rd_chk(8'(`EP_RD_BASE + i), 8'h00);
        rd_chk(`ADDR_RD, 8'h00);
        for (int i = 0; i < 16; i++) begin
            ep_val[i] = i < 2 ? ctl_default : 8'($random(seed));
            i_fw_port_model.access(8'(`EP_WR_BASE + i), ep_val[i], q);
        end
        repeat (3) @(negedge mclk);
        chk(n_alloc, 1);
        chk(ep_enabled, en_map());
        for (int i = 0; i < 16; i++) rd_chk(8'(`EP_RD_BASE + i), ep_val[i]);
        cfg_sel = 4'($random(seed));
        repeat (2) @(negedge mclk);
        chk(sel_config, ep_val[cfg_sel]);
        ep_val[3] ^= 8'h01;
        ep_val[4] ^= 8'h40;
        for (int i = 3; i < 5; i++) i_fw_port_model.access(8'(`EP_WR_BASE + i), ep_val[i], q);
        repeat (2) @(negedge mclk);
        chk(n_inval, 1);
        m = 8'($random(seed)) & 8'hDF;
        i_fw_port_model.access(`MODE_WR, m | 8'h20, q);
        i_fw_port_model.access(`MODE_WR, m, q);
        repeat (2) @(negedge mclk);
        chk({dma_width_select, interrupt_output_enable, debug_all_events, soft_bus_attach},
            {m[7], m[3:2], m[0]});
        chk(n_susp, 1);
        rd_chk(`MODE_RD, m);
        i_fw_port_model.access(`ADDR_WR, 8'h85, q);
        repeat (2) @(negedge mclk);
        chk({device_enable, active_address}, 8'h80);
        status_ack = 1'b1;
        @(negedge mclk);
        status_ack = 1'b0;
        @(negedge mclk);
        chk(active_address, 7'h05);
        rd_chk(`ADDR_RD, 8'h85);
        // a write landing inside the bus reset must be dropped
        usb_bus_reset = 1'b1;
        i_fw_port_model.access(`ADDR_WR, 8'h00, q);
        usb_bus_reset = 1'b0;
        repeat (3) @(negedge mclk);
        chk({device_enable, active_address}, 8'h80);
        chk(ep_enabled, 16'h0000);
        chk(n_inval > 1, 1);
        rd_chk(`ADDR_RD, 8'h85);
        rd_chk(`MODE_RD, m & `MODE_KEEP_MASK);
        rd_chk(8'h35, ep_val[5] & 8'h7F);
        nrst = 1'b0;
        @(negedge mclk);
        nrst = 1'b1;
        rd_chk(`MODE_RD, 8'h00);
        give_verdict();
    end
endmodule // usb_device_init_config_regs_tb_top
bind cfg_regs cfg_regs_chk #(.num_ep(num_ep)) i_cfg_regs_chk (.*);
